// >>> logic/serial_port.sv
// Serial port control, status, transmit FIFO and shift engines behind an AHB-Lite slave
// How it works
// - Parity select bit: 0 gives even parity, 1 gives odd parity.
// - Modes 2 and 3 send the ninth-bit control; it clears after each frame.
// - With parity enabled the computed parity replaces the sent ninth bit (data bit 7 in mode 1).
// - Receive enabled in modes 1-3: falling edge on serial input starts reception.
// - Mode 0 transmits only with receive disabled, receives only with it enabled.
// - Clearing receive enable aborts reception and blocks new ones.
// - Parity enable in modes 1 and 3 generates and checks parity.
// - Two-bit mode field: 00 mode 0, 01 mode 1, 10 mode 2, 11 mode 3.
// - Parity enabled: status bit 7 reports a receive parity error.
// - Parity disabled: bit 7 is the received ninth bit; status read clears it.
// - Receive-done bit 6 sets at last data sample, clears on status read.
// - Transmit-done bit 5 sets as stop bit starts (at frame end in mode 0), clears on status read.
// - Framing error bit 4 sets on missing stop bit, clears on status read.
// - Transmit-empty bit 3 set when the queue is empty, even while the shifter still sends; cleared by buffer write.
// - Overrun bit 2 sets when an unread byte is overwritten; status read clears.
// - Control bit 6 enables a divide-by-two prescaler on the serial clock.
// - Buffer write starts transmission in modes 1-3; mode 0 only receiver off.
`timescale 1ns/1ps
`include "serial_port_regs.svh"
`default_nettype none

module tx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty
   assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr_r[AW-1:0]];

   // Storage has no reset; only pointers define contents
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   // Pointer update
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (in_valid && !full) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule : tx_fifo

module serial_port
   import serial_port_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic txd,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe
);

   ctrl_t ctrl_r;
   logic [7:0] flag_r;
   logic [7:0] rx_hold_r;
   logic [15:0] baud_r;
   logic rx_unread_r;
   logic ren_q_r;

   logic dp_wr_r;
   logic [12:0] dp_idx_r;
   logic [31:0] hrdata_r;
   logic ap_take;
   logic ap_rd_flag;
   logic ap_rd_rxhold;
   logic wr_act;

   logic [14:0] bcnt_r;
   logic bph_r;
   logic base_tick;
   logic tick;

   logic rxd_s1_r;
   logic rxd_s2_r;
   logic rxd_s3_r;
   logic rx_fall;

   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   tx_word_t fifo_in_data;
   tx_word_t fifo_out_data;

   tx_state_t tx_st_r;
   logic [10:0] tx_sh_r;
   logic [3:0] tx_left_r;
   logic [3:0] tx_sub_r;
   logic tx_ph_r;
   logic tx_stop_ev;
   logic tx_done_ev;
   logic par_en;
   logic [10:0] frame;

   rx_state_t rx_st_r;
   logic [8:0] rx_sh_r;
   logic [8:0] rx_word;
   logic [3:0] rx_idx_r;
   logic [3:0] rx_sub_r;
   logic [3:0] rx_left_r;
   logic rx_ph_r;
   logic [3:0] rx_nd;
   logic rx_async_smp;
   logic rx_last_ev;
   logic rx_err_ev;
   logic fe_ev;
   logic [7:0] rx_data;
   logic rx_bit7;
   logic txd_r;

   // Parity bit that makes the total count even, or odd when odd_sel is set
   function automatic logic par_bit(input logic [7:0] d, input logic odd_sel);
      par_bit = (^d) ^ odd_sel;
   endfunction : par_bit

   // Selected mode decode
   function automatic logic is_mode(input logic [1:0] fld, input logic [1:0] m);
      is_mode = (fld == m);
   endfunction : is_mode

   // AHB address phase: reads are answered from a flop in the following data phase
   assign ap_take = hsel && htrans[1] && hready;
   assign ap_rd_flag = ap_take && !hwrite && (haddr[14:2] == `IDX_FLAG);
   assign ap_rd_rxhold = ap_take && !hwrite && (haddr[14:2] == `IDX_RX_HOLD);
   // A transmit write stalls the bus while the FIFO is full
   assign fifo_in_valid = dp_wr_r && (dp_idx_r == `IDX_TX_HOLD);
   assign hreadyout = !(fifo_in_valid && !fifo_in_ready);
   assign wr_act = dp_wr_r && hreadyout;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r <= 1'b0;
         dp_idx_r <= '0;
         hrdata_r <= '0;
      end else if (hready) begin
         dp_wr_r <= ap_take && hwrite;
         dp_idx_r <= haddr[14:2];
         if (ap_take && !hwrite) begin
            case (haddr[14:2])
               `IDX_RX_HOLD: hrdata_r <= {24'h000000, rx_hold_r};
               `IDX_FLAG: hrdata_r <= {24'h000000, flag_r[7:2], `FLG_RSVD_VAL};
               `IDX_TX_HOLD: hrdata_r <= {24'h000000, fifo_out_data.data};
               `IDX_CONTROL: hrdata_r <= {24'h000000, ctrl_r};
               `IDX_BAUD: hrdata_r <= {16'h0000, baud_r};
               default: hrdata_r <= '0;
            endcase
         end
      end
   end

   // Control register; a software write beats the ninth-bit clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= `RST_CONTROL;
         ren_q_r <= 1'b0;
      end else begin
         ren_q_r <= ctrl_r.rx_enable;
         if (wr_act && dp_idx_r == `IDX_CONTROL) begin
            ctrl_r <= hwdata[7:0];
         end else if (tx_done_ev && !is_mode(ctrl_r.link_mode_field, 2'b00)) begin
            ctrl_r.tx_ninth_bit <= 1'b0;
         end
      end
   end

   // Baud register; clock source bit stored but unused
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         baud_r <= `RST_BAUD;
      end else if (wr_act && dp_idx_r == `IDX_BAUD) begin
         baud_r <= hwdata[15:0];
      end
   end

   // Baud divider: one tick every value+1 clocks, every second one when halved
   assign base_tick = (bcnt_r == 15'h0000);
   assign tick = base_tick && (!ctrl_r.halve_clock || bph_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bcnt_r <= '0;
         bph_r <= 1'b0;
      end else if (base_tick) begin
         bcnt_r <= baud_r[14:0];
         bph_r <= !bph_r;
      end else begin
         bcnt_r <= bcnt_r - 1'b1;
      end
   end

   // Serial input synchroniser; the third stage only serves edge detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rxd_s1_r <= 1'b1;
         rxd_s2_r <= 1'b1;
         rxd_s3_r <= 1'b1;
      end else begin
         rxd_s1_r <= rxd_in;
         rxd_s2_r <= rxd_s1_r;
         rxd_s3_r <= rxd_s2_r;
      end
   end
   assign rx_fall = rxd_s3_r && !rxd_s2_r;

   // Transmit queue; the ninth-bit control is captured with each byte
   assign fifo_in_data = '{ninth: ctrl_r.tx_ninth_bit, data: hwdata[7:0]};
   assign fifo_out_ready = (tx_st_r == TX_IDLE)
      && (!is_mode(ctrl_r.link_mode_field, 2'b00) || (!ctrl_r.rx_enable && rx_st_r == RX_IDLE));

   tx_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk(hclk),
      .rst_n(hresetn),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // Parity only in modes 1 and 3; mode 2 ignores the enable
   assign par_en = ctrl_r.check_enable && ctrl_r.link_mode_field[0];

   // Frame image, LSB first; start bit at bit 0 in modes 1-3 (mode 0 has none), an idle one above the stop bit in mode 1 only
   always_comb begin
      frame = 11'h7ff;
      case (ctrl_r.link_mode_field)
         2'b00: frame = {3'b111, fifo_out_data.data};
         2'b01: frame = {2'b11, (par_en ? par_bit({1'b0, fifo_out_data.data[6:0]},
            ctrl_r.odd_polarity_select) : fifo_out_data.data[7]),
            fifo_out_data.data[6:0], 1'b0};
         default: frame = {1'b1, (par_en ? par_bit(fifo_out_data.data, ctrl_r.odd_polarity_select)
            : fifo_out_data.ninth), fifo_out_data.data, 1'b0};
      endcase
   end

   // Transmit events
   assign tx_stop_ev = (tx_st_r == TX_ASYNC) && tick && (tx_sub_r == `TICKS_PER_BIT)
      && (tx_left_r == 4'h2);
   assign tx_done_ev = tick && (tx_left_r == 4'h1)
      && (((tx_st_r == TX_ASYNC) && (tx_sub_r == `TICKS_PER_BIT)) || ((tx_st_r == TX_SYNC) && tx_ph_r));

   // Transmit engine: async frames at 16 ticks a bit, mode 0 at 2 ticks a bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_st_r <= TX_IDLE;
         tx_sh_r <= 11'h7ff;
         tx_left_r <= '0;
         tx_sub_r <= '0;
         tx_ph_r <= 1'b0;
      end else begin
         case (tx_st_r)
            TX_IDLE: begin
               tx_sub_r <= '0;
               tx_ph_r <= 1'b0;
               if (fifo_out_valid && fifo_out_ready) begin
                  tx_sh_r <= frame;
                  if (is_mode(ctrl_r.link_mode_field, 2'b00)) begin
                     tx_st_r <= TX_SYNC;
                     tx_left_r <= `SYNC_BITS;
                  end else begin
                     tx_st_r <= TX_ASYNC;
                     tx_left_r <= ctrl_r.link_mode_field[1] ? 4'hb : 4'ha;
                  end
               end
            end
            TX_ASYNC: begin
               if (tick) begin
                  tx_sub_r <= tx_sub_r + 1'b1;
                  if (tx_sub_r == `TICKS_PER_BIT) begin
                     tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                     tx_left_r <= tx_left_r - 1'b1;
                     if (tx_left_r == 4'h1) begin
                        tx_st_r <= TX_IDLE;
                     end
                  end
               end
            end
            TX_SYNC: begin
               if (tick) begin
                  tx_ph_r <= !tx_ph_r;
                  if (tx_ph_r) begin
                     tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                     tx_left_r <= tx_left_r - 1'b1;
                     if (tx_left_r == 4'h1) begin
                        tx_st_r <= TX_IDLE;
                     end
                  end
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // Receive word: data bits land in the top of the shifter
   assign rx_nd = ctrl_r.link_mode_field[1] ? 4'h9 : 4'h8;
   assign rx_word = {rxd_s2_r, rx_sh_r[8:1]};
   assign rx_async_smp = (rx_st_r == RX_ASYNC) && ctrl_r.rx_enable && tick
      && (rx_sub_r == `SAMPLE_TICK);
   assign rx_last_ev = (rx_async_smp && (rx_idx_r == rx_nd))
      || ((rx_st_r == RX_SYNC) && ctrl_r.rx_enable && tick && !rx_ph_r && (rx_left_r == 4'h1));
   assign fe_ev = rx_async_smp && (rx_idx_r == rx_nd + 4'h1) && !rxd_s2_r;

   // Received data and ninth bit or check error per mode
   always_comb begin
      rx_data = rx_word[8:1];
      rx_bit7 = 1'b0;
      rx_err_ev = 1'b0;
      if (rx_st_r == RX_ASYNC && ctrl_r.link_mode_field[1]) begin
         rx_data = rx_word[7:0];
         rx_bit7 = rx_word[8];
         rx_err_ev = par_bit(rx_word[7:0], ctrl_r.odd_polarity_select) != rx_word[8];
      end else if (rx_st_r == RX_ASYNC) begin
         rx_err_ev = par_bit({1'b0, rx_word[7:1]}, ctrl_r.odd_polarity_select) != rx_word[8];
      end
      if (par_en) begin
         rx_bit7 = rx_err_ev;
      end
   end

   // Receive engine; dropping the enable abandons any frame at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_st_r <= RX_IDLE;
         rx_sh_r <= '0;
         rx_idx_r <= '0;
         rx_sub_r <= '0;
         rx_left_r <= '0;
         rx_ph_r <= 1'b0;
      end else if (!ctrl_r.rx_enable) begin
         rx_st_r <= RX_IDLE;
      end else begin
         case (rx_st_r)
            RX_IDLE: begin
               rx_sub_r <= '0;
               rx_idx_r <= '0;
               rx_ph_r <= 1'b0;
               if (!is_mode(ctrl_r.link_mode_field, 2'b00) && rx_fall) begin
                  rx_st_r <= RX_ASYNC;
               end else if (is_mode(ctrl_r.link_mode_field, 2'b00) && !ren_q_r
                  && tx_st_r == TX_IDLE) begin
                  rx_st_r <= RX_SYNC;
                  rx_left_r <= `SYNC_BITS;
               end
            end
            RX_ASYNC: begin
               if (tick) begin
                  rx_sub_r <= rx_sub_r + 1'b1;
               end
               if (rx_async_smp) begin
                  rx_idx_r <= rx_idx_r + 1'b1;
                  if (rx_idx_r == 4'h0 && rxd_s2_r) begin
                     rx_st_r <= RX_IDLE; // Start bit gone by mid-bit: a glitch
                  end else if (rx_idx_r == rx_nd + 4'h1) begin
                     rx_st_r <= RX_IDLE;
                  end else if (rx_idx_r != 4'h0) begin
                     rx_sh_r <= rx_word;
                  end
               end
            end
            RX_SYNC: begin
               if (tick) begin
                  rx_ph_r <= !rx_ph_r;
                  if (!rx_ph_r) begin
                     rx_sh_r <= rx_word;
                     rx_left_r <= rx_left_r - 1'b1;
                  end else if (rx_left_r == 4'h0) begin
                     rx_st_r <= RX_IDLE;
                  end
               end
            end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   // Holding buffer always takes the newest byte, never a mix
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_hold_r <= `RST_RX_HOLD;
         rx_unread_r <= 1'b0;
      end else if (rx_last_ev) begin
         rx_hold_r <= rx_data;
         rx_unread_r <= 1'b1;
      end else if (ap_rd_rxhold) begin
         rx_unread_r <= 1'b0;
      end
   end

   // Status flags; hardware set wins over a same-cycle status read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r <= `RST_FLAG;
      end else begin
         if (ap_rd_flag) begin
            flag_r[`FLG_NINTH_ERR] <= 1'b0;
            flag_r[`FLG_RX_DONE] <= 1'b0;
            flag_r[`FLG_TX_DONE] <= 1'b0;
            flag_r[`FLG_FRAMING] <= 1'b0;
            flag_r[`FLG_OVERRUN] <= 1'b0;
         end
         if (rx_last_ev) begin
            flag_r[`FLG_RX_DONE] <= 1'b1;
            flag_r[`FLG_NINTH_ERR] <= rx_bit7 || (flag_r[`FLG_NINTH_ERR] && !ap_rd_flag);
         end
         if (rx_last_ev && rx_unread_r && !ap_rd_rxhold) begin
            flag_r[`FLG_OVERRUN] <= 1'b1;
         end
         if (tx_stop_ev || (tx_done_ev && tx_st_r == TX_SYNC)) begin
            flag_r[`FLG_TX_DONE] <= 1'b1;
         end
         if (fe_ev) begin
            flag_r[`FLG_FRAMING] <= 1'b1;
         end
         // Empty follows the queue; a buffer write makes it non-empty next cycle
         flag_r[`FLG_TX_EMPTY] <= !fifo_out_valid && !(wr_act && fifo_in_valid);
         flag_r[1:0] <= `FLG_RSVD_VAL;
      end
   end

   // Pin drive: mode 0 puts the shift clock on txd and data on the serial data pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txd_r <= 1'b1;
      end else if (tx_st_r == TX_SYNC) begin
         txd_r <= tx_ph_r;
      end else if (rx_st_r == RX_SYNC) begin
         txd_r <= rx_ph_r;
      end else begin
         txd_r <= (tx_st_r == TX_ASYNC) ? tx_sh_r[0] : 1'b1;
      end
   end

   assign txd = txd_r;
   assign rxd_out = tx_sh_r[0];
   assign rxd_oe = (tx_st_r == TX_SYNC);

endmodule : serial_port
`default_nettype wire

// >>> logic/serial_port_pkg.sv
// Types shared by the serial port control and status block
package serial_port_pkg;

   // Control register layout
   typedef struct packed {
      logic rsvd;
      logic halve_clock;
      logic odd_polarity_select;
      logic tx_ninth_bit;
      logic rx_enable;
      logic check_enable;
      logic [1:0] link_mode_field;
   } ctrl_t;

   // One queued transmit byte with its ninth bit
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } tx_word_t;

   typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} rx_state_t;

endpackage : serial_port_pkg

// >>> logic/serial_port_regs.svh
// Register indices, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_RX_HOLD 13'h1fb8
`define IDX_FLAG 13'h1fb9
`define IDX_TX_HOLD 13'h1fba
`define IDX_CONTROL 13'h1fbb
`define IDX_BAUD 13'h1fbc

// Reset values
`define RST_FLAG 8'h0b
`define RST_CONTROL 8'h00
`define RST_RX_HOLD 8'h00
`define RST_BAUD 16'h0000

// Flag register bit positions
`define FLG_NINTH_ERR 7
`define FLG_RX_DONE 6
`define FLG_TX_DONE 5
`define FLG_FRAMING 4
`define FLG_TX_EMPTY 3
`define FLG_OVERRUN 2
`define FLG_RSVD_VAL 2'b11

// Oversampling: last tick of each 16-tick async bit and the mid-bit sample tick
`define TICKS_PER_BIT 4'hf
`define SAMPLE_TICK 4'h7
`define SYNC_BITS 4'h8

`endif

// >>> verification/serial_peer.sv
// Remote serial station: sends frames to the receive pin, captures frames from txd
`timescale 1ns/1ps
`default_nettype none

module serial_peer #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk,
   input wire logic txd,
   output logic line
);
   logic listen = 1'b0;
   int nbits = 8;
   int cnt = 0;
   logic [9:0] last = 10'h0;
   logic [9:0] v;

   initial line = 1'b1;

   // One frame LSB first, start bit included; then idle high
   task automatic send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         line <= f[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      line <= 1'b1;
   endtask : send

   // Mid-bit sampling; stop bit lands above the data
   always begin
      @(negedge txd);
      if (listen) begin
         repeat (BIT_CLKS / 2) @(posedge clk);
         v = 10'h0;
         for (int i = 0; i <= nbits; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            v[i] = txd;
         end
         last = v;
         cnt++;
      end
   end
endmodule : serial_peer

`default_nettype wire

// >>> verification/serial_port_sva.sv
// Port-level checker for the serial port block
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.svh"

module serial_port_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic rxd_oe
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic take;
   logic wpend_r;
   logic [7:0] ctrl_r;

   assign take = hsel && htrans[1] && hready;

   // Shadow of the control register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wpend_r <= 1'b0;
         ctrl_r <= `RST_CONTROL;
      end else if (hready) begin
         if (wpend_r) ctrl_r <= hwdata[7:0];
         wpend_r <= take && hwrite && haddr[14:2] == `IDX_CONTROL;
      end
   end

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("slave response is not OKAY");
   a_stall_cause: assert property ($fell(hreadyout) |->
      $past(take && hwrite && haddr[14:2] == `IDX_TX_HOLD))
      else $error("stall outside tx write");
   a_stall_bound: assert property (!hreadyout |-> ##[1:1000] hreadyout)
      else $error("stall never ends");
   a_rsvd_ones: assert property (take && !hwrite && haddr[14:2] == `IDX_FLAG
      |=> hrdata[1:0] == `FLG_RSVD_VAL)
      else $error("flag low bits wrong");
   a_unmapped_zero: assert property (take && !hwrite &&
      (haddr[14:2] < `IDX_RX_HOLD || haddr[14:2] > `IDX_BAUD) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_hold_rdata: assert property (!$past(take) |-> $stable(hrdata))
      else $error("read data moved");
   a_ctrl_readback: assert property (
      take && !hwrite && haddr[14:2] == `IDX_CONTROL
      |=> (hrdata[7:0] & 8'hef) == ($past(ctrl_r) & 8'hef))
      else $error("control readback wrong");
   a_oe_mode_zero: assert property (
      $rose(rxd_oe) |-> ctrl_r[1:0] == 2'b00 && !ctrl_r[3])
      else $error("pin driven outside mode 0");
endmodule : serial_port_sva

bind serial_port serial_port_sva serial_port_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .rxd_oe);

`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.svh"

module tb_top;
   typedef struct packed {
      logic w;
      logic [12:0] idx;
      logic [31:0] d;
      logic [31:0] m;
   } row_t;

   localparam int FRAME = 220;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic txd;
   logic rxd_out;
   logic rxd_oe;
   logic line;
   logic rxd_in;
   logic [31:0] x;
   logic stall_seen = 1'b0;
   logic oe_seen = 1'b0;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   int n0;
   logic [7:0] par_ctrl [4] = '{8'h07, 8'h37, 8'h05, 8'h25};
   logic [9:0] par_exp [4] = '{10'h383, 10'h283, 10'h103, 10'h183};
   row_t rows [14] = '{
      '{1'b0, `IDX_FLAG, 32'h0b, 32'hff},
      '{1'b0, `IDX_CONTROL, 32'h00, 32'hff},
      '{1'b0, `IDX_RX_HOLD, 32'h00, 32'hff},
      '{1'b0, `IDX_BAUD, 32'h0000, 32'hffff},
      '{1'b1, `IDX_FLAG, 32'hf4, 32'h0},
      '{1'b0, `IDX_FLAG, 32'h0b, 32'hff},
      '{1'b1, 13'h1fbd, 32'h55, 32'h0},
      '{1'b0, 13'h1fbd, 32'h0, 32'hffffffff},
      '{1'b1, `IDX_CONTROL, 32'h02, 32'h0},
      '{1'b0, `IDX_CONTROL, 32'h02, 32'hff},
      '{1'b1, `IDX_CONTROL, 32'h03, 32'h0},
      '{1'b0, `IDX_CONTROL, 32'h03, 32'hff},
      '{1'b1, `IDX_BAUD, 32'h8001, 32'h0},
      '{1'b0, `IDX_BAUD, 32'h8001, 32'hffff}};

   // Shared pin: block drives it in mode 0 transmit
   assign rxd_in = rxd_oe ? rxd_out : line;

   serial_port #(.FIFO_DEPTH(16)) serial_port_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .txd, .rxd_in, .rxd_out, .rxd_oe);
   serial_peer serial_peer_i (.clk(hclk), .txd, .line);

   always #2 hclk = ~hclk;

   // Sticky pin observations and the hang guard
   always @(posedge hclk) begin
      cyc++;
      if (!hreadyout) stall_seen = 1'b1;
      if (rxd_oe) oe_seen = 1'b1;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // Single transfer; each phase holds until hready is seen high at an edge
   task automatic bus(input logic w, input logic [12:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {17'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [12:0] idx, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, idx, d, v);
   endtask : wr

   task automatic rdm(input logic [12:0] idx, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      bus(1'b0, idx, 32'h0, v);
      chk(v & m, e);
   endtask : rdm

   task automatic chkf(input logic [9:0] e);
      repeat (FRAME) @(posedge hclk);
      chk({22'h0, serial_peer_i.last}, {22'h0, e});
   endtask : chkf

   task automatic rx(input logic [10:0] f, input int n);
      serial_peer_i.send(f, n);
      repeat (8) @(posedge hclk);
   endtask : rx

   task automatic rdf(input logic [7:0] e);
      rdm(`IDX_FLAG, 32'hff, {24'h0, e});
   endtask : rdf

   task automatic finish_test();
      if (fails == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].idx, rows[i].d, x);
         if (!rows[i].w) chk(x & rows[i].m, rows[i].d);
      end
      // Mode 1 transmit with done and empty flags
      wr(`IDX_BAUD, 32'h0);
      serial_peer_i.listen = 1'b1;
      wr(`IDX_CONTROL, 32'h01);
      wr(`IDX_TX_HOLD, 32'ha5);
      chkf(10'h1a5);
      rdf(8'h2b);
      rdf(8'h0b);
      // Mode 3 ninth bit, cleared once the frame is sent
      serial_peer_i.nbits = 9;
      wr(`IDX_CONTROL, 32'h13);
      wr(`IDX_TX_HOLD, 32'h3c);
      chkf(10'h33c);
      rdm(`IDX_CONTROL, 32'hff, 32'h03);
      wr(`IDX_TX_HOLD, 32'h3c);
      chkf(10'h23c);
      // Generated parity, both senses, modes 3 and 1
      for (int i = 0; i < 4; i++) begin
         serial_peer_i.nbits = (i < 2) ? 9 : 8;
         wr(`IDX_CONTROL, {24'h0, par_ctrl[i]});
         wr(`IDX_TX_HOLD, 32'h83);
         chkf(par_exp[i]);
      end
      // Overfill: the bus stalls, yet every byte goes out
      stall_seen = 1'b0;
      n0 = serial_peer_i.cnt;
      wr(`IDX_CONTROL, 32'h01);
      for (int i = 0; i < 18; i++) wr(`IDX_TX_HOLD, 32'(i));
      rdm(`IDX_FLAG, 32'h08, 32'h00);
      chk({31'h0, stall_seen}, 32'h1);
      repeat (3000) @(posedge hclk);
      chk(32'(serial_peer_i.cnt - n0), 32'd18);
      chkf(10'h111);
      rdf(8'h2b);
      // Mode 1 reception: done flag, data, overrun, framing
      wr(`IDX_CONTROL, 32'h09);
      rx({2'b01, 8'h5a, 1'b0}, 10);
      rdf(8'h4b);
      rdm(`IDX_RX_HOLD, 32'hff, 32'h5a);
      serial_peer_i.send({2'b01, 8'h11, 1'b0}, 10);
      rx({2'b01, 8'h22, 1'b0}, 10);
      rdf(8'h4f);
      rdm(`IDX_RX_HOLD, 32'hff, 32'h22);
      rx({2'b00, 8'h33, 1'b0}, 10);
      rdf(8'h5b);
      rdf(8'h0b);
      bus(1'b0, `IDX_RX_HOLD, 32'h0, x);
      // Mode 3 reception: ninth bit, then parity errors, even sense
      wr(`IDX_CONTROL, 32'h0b);
      rx({2'b11, 8'h44, 1'b0}, 11);
      rdf(8'hcb);
      rdf(8'h0b);
      rdm(`IDX_RX_HOLD, 32'hff, 32'h44);
      wr(`IDX_CONTROL, 32'h0f);
      rx({2'b11, 8'h03, 1'b0}, 11);
      rdf(8'hcb);
      bus(1'b0, `IDX_RX_HOLD, 32'h0, x);
      rx({2'b11, 8'h07, 1'b0}, 11);
      rdf(8'h4b);
      // Receiver off in mid-frame: nothing is reported
      fork
         serial_peer_i.send({2'b11, 8'h07, 1'b0}, 11);
         begin
            repeat (60) @(posedge hclk);
            wr(`IDX_CONTROL, 32'h03);
         end
      join
      rx({2'b11, 8'h07, 1'b0}, 11);
      rdf(8'h0b);
      // Mode 0: an enabled receiver holds the byte back
      serial_peer_i.listen = 1'b0;
      wr(`IDX_BAUD, 32'h1);
      oe_seen = 1'b0;
      wr(`IDX_CONTROL, 32'h08);
      wr(`IDX_TX_HOLD, 32'h81);
      rdm(`IDX_FLAG, 32'h08, 32'h00);
      repeat (100) @(posedge hclk);
      chk({31'h0, oe_seen}, 32'h0);
      wr(`IDX_CONTROL, 32'h00);
      repeat (100) @(posedge hclk);
      chk({31'h0, oe_seen}, 32'h1);
      rdm(`IDX_FLAG, 32'h28, 32'h28);
      // Reset in mid-run restores the reset values
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rdm(`IDX_CONTROL, 32'hff, 32'h00);
      rdf(8'h0b);
      finish_test();
   end
endmodule : tb_top

`default_nettype wire
